//--- asd_regs.svh
// Constants for the serial command decoder of the converter.
`ifndef ASD_REGS_SVH
`define ASD_REGS_SVH
// Full opcodes that are decoded on all eight bits.
`define ASD_OP_IDLE 8'h00
`define ASD_OP_SYS_OFS_CAL 8'h16
`define ASD_OP_SYS_GAIN_CAL 8'h17
`define ASD_OP_SELF_OFS_CAL 8'h19
// Opcodes whose least significant bit is a don't care, kept as the upper seven bits.
`define ASD_OP7_EXIT_SLEEP 7'h01
`define ASD_OP7_SLEEP 7'h02
`define ASD_OP7_RESET 7'h03
`define ASD_OP7_START 7'h04
`define ASD_OP7_STOP 7'h05
`define ASD_OP7_READ_DATA 7'h09
// Three-bit prefixes of the multibyte register commands.
`define ASD_OP3_REG_READ 3'h1
`define ASD_OP3_REG_WRITE 3'h2
// Highest implemented register address; the map itself lives outside.
`define ASD_LAST_REG 5'h11
// Bit index of the last bit of a byte, and of the seventh bit.
`define ASD_BIT_LAST 3'h7
`define ASD_BIT_SEVENTH 3'h6
// Conversion result bytes beyond the first one.
`define ASD_DATA_EXTRA 5'h02
// Power-down entry delay after the seventh falling edge, in master clocks.
`define ASD_SLEEP_TCLK 2
`define ASD_SLEEP_CYC 2'(`ASD_SLEEP_TCLK)
// Serial timeout window, in master clocks (two to the fifteenth).
`define ASD_TIMEOUT_TCLK 32768
// Reset levels of the synchronised pins: cs_n and reset pin idle high.
`define ASD_PIN_RST 5'h11
`endif

//--- asd_pkg.sv
// Types shared by the serial command decoder files.
package asd_pkg;
	// Converter operating mode, one-hot.
	typedef enum logic [4:0] {
		ASD_MD_STANDBY = 5'h01,
		ASD_MD_CONVERT = 5'h02,
		ASD_MD_STOPPING = 5'h04,
		ASD_MD_SLEEPW = 5'h08,
		ASD_MD_PD = 5'h10
	} asd_mode_e;
	// Serial transfer phase, one-hot.
	typedef enum logic [4:0] {
		ASD_SP_CMD = 5'h01,
		ASD_SP_CNT = 5'h02,
		ASD_SP_RDOUT = 5'h04,
		ASD_SP_WDATA = 5'h08,
		ASD_SP_DATA = 5'h10
	} asd_xfer_e;
	// Kind of calibration in progress.
	typedef enum logic [1:0] {
		ASD_CAL_SYS_OFS = 2'h0,
		ASD_CAL_SYS_GAIN = 2'h1,
		ASD_CAL_SELF_OFS = 2'h2
	} asd_cal_e;
endpackage : asd_pkg

//--- asd_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/100ps
module asd_sync #(
	parameter int W = 5,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	genvar gi;
	// Each pin gets its own chain; only the second stage reads the first.
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			// A change is accepted once the second and third stages agree.
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					s1_q <= RST_VAL[gi];
					s2_q <= RST_VAL[gi];
					s3_q <= RST_VAL[gi];
					q[gi] <= RST_VAL[gi];
				end else if (clk_en) begin
					s1_q <= d[gi];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						q[gi] <= s3_q;
					end
				end
			end
		end
	endgenerate
endmodule : asd_sync

//--- asd_decoder.sv
// Serial command decoder of the delta-sigma converter, on the master clock.
// Behaviour
// - All-zero opcode is idle, changes nothing.
// - Exit-sleep leaves power-down into standby.
// - Sleep aborts conversion, powers down after delay.
// - Power-down accepts only reads and exit-sleep.
// - Reset clears filter, defaults registers, standby.
// - Reset command selects internal oscillator.
// - Start converts continuously, or once single-shot.
// - Start ignored when start pin high or converting.
// - Stop ends after current conversion; single-shot ignores.
// - Three calibrations update correction registers on completion.
// - Read-data returns result from holding buffer.
// - Register read: address byte, count byte, MSB first.
// - Register read past map returns zero bytes.
// - Register transfer blocks loading new results.
// - Register transfer blocks commands until ended.
// - Register write: address, count, consecutive data bytes.
// - Register write past map discards data.
// - Chip select high aborts the current command.
// - Capture on falling, change on rising sclk.
// - Chip select high resets interface, floats output.
// - Timeout resets interface when enabled.
`timescale 1ns/100ps
`include "asd_regs.svh"
module asd_decoder #(
	parameter int TIMEOUT_CYC = `ASD_TIMEOUT_TCLK // Serial timeout in master clocks.
) (
	input wire logic clk, // Master clock, 100 MHz.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic clk_en, // Freezes all state while low.
	input wire logic cs_n_pin, // Chip select pin, active low.
	input wire logic sclk_pin, // Serial clock pin.
	input wire logic din_pin, // Serial data in pin.
	input wire logic start_pin, // Start/sync pin.
	input wire logic rst_pin_n, // Reset pin, active low.
	input wire logic cfg_single_shot, // Single-shot conversion mode from config.
	input wire logic cfg_timeout_en, // Serial timeout enable from config.
	input wire logic conv_done, // One-cycle pulse: a conversion finished.
	input wire logic [23:0] result_data, // Result that goes with conv_done.
	input wire logic cal_done, // One-cycle pulse: calibration finished.
	input wire logic [7:0] reg_rdata, // Register map data at reg_addr_q.
	output logic dout_q, // Serial data out.
	output logic dout_oe_q, // Output enable of the serial data pin.
	output logic [4:0] reg_addr_q, // Register map address.
	output logic [7:0] reg_wdata_q, // Register map write data.
	output logic reg_we_q, // Register map write strobe.
	output logic converting_q, // Conversions running.
	output logic powered_down_q, // Power-down mode.
	output logic conv_start_q, // Pulse: start conversions.
	output logic conv_abort_q, // Pulse: abort running conversion.
	output logic filter_clr_q, // Pulse: clear digital filter.
	output logic cfg_default_q, // Pulse: registers to defaults.
	output logic int_osc_sel_q, // Pulse: select internal oscillator.
	output logic cal_start_q, // Pulse: start calibration.
	output asd_pkg::asd_cal_e cal_kind_q, // Kind of calibration.
	output logic inputs_short_q, // Inputs shorted internally.
	output logic offset_correction_upd_q, // Pulse: update offset correction.
	output logic fullscale_correction_upd_q, // Pulse: update full-scale correction.
	output logic shift_load_block_q // Results kept out of the shift register.
);
	logic [4:0] pins; // Filtered pin levels.
	logic s_cs_n, s_sclk, s_din, s_start, s_rstp;
	logic sclk_prev_q; // Previous filtered sclk level.
	logic [2:0] bit_cnt_q; // Bit position within the byte.
	logic [6:0] sh_q; // Received bits so far.
	logic [7:0] op; // Byte completed by the current falling edge.
	logic fall, rise, act, bdone, abort, tmo_fire;
	asd_pkg::asd_xfer_e sp_q; // Transfer phase.
	asd_pkg::asd_mode_e md_q; // Operating mode.
	logic wr_q; // Multibyte command is a write.
	logic [4:0] start_q; // Start address of register transfer.
	logic [4:0] left_q; // Bytes left after the current one.
	logic oor_q; // Address has run past the map.
	logic adv_q; // Advance the address next cycle.
	logic load_q; // Load next register byte for output.
	logic [23:0] tx_q; // Output shift register.
	logic [23:0] hold_q; // Result holding buffer.
	logic [1:0] slp_cnt_q; // Power-down entry delay.
	logic cal_busy_q; // Calibration running.
	logic [15:0] tmo_cnt_q; // Timeout counter.
	logic cmd_done, go, pd, sleep_hit;
	logic is_idle, is_wake, is_reset, is_start, is_stop, is_rdata, is_register_read_cmd, is_register_write_cmd, is_cal;

	// Every pin is foreign to the master clock, so all pass the filter.
	asd_sync #(.W(5), .RST_VAL(`ASD_PIN_RST)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.d({rst_pin_n, start_pin, din_pin, sclk_pin, cs_n_pin}),
		.q(pins)
	);
	assign s_cs_n = pins[0];
	assign s_sclk = pins[1];
	assign s_din = pins[2];
	assign s_start = pins[3];
	assign s_rstp = pins[4];

	// Edges of the sampled serial clock; a frame exists only under chip select.
	assign act = ~s_cs_n;
	assign fall = act & sclk_prev_q & ~s_sclk;
	assign rise = act & ~sclk_prev_q & s_sclk;
	assign bdone = fall & (bit_cnt_q == `ASD_BIT_LAST);
	assign op = {sh_q, s_din};
	assign abort = s_cs_n | ~s_rstp | tmo_fire;

	// Opcode classes; the don't-care bit is dropped where it exists.
	assign is_idle = (op == `ASD_OP_IDLE);
	assign is_wake = (op[7:1] == `ASD_OP7_EXIT_SLEEP);
	assign is_reset = (op[7:1] == `ASD_OP7_RESET);
	assign is_start = (op[7:1] == `ASD_OP7_START);
	assign is_stop = (op[7:1] == `ASD_OP7_STOP);
	assign is_rdata = (op[7:1] == `ASD_OP7_READ_DATA);
	assign is_register_read_cmd = (op[7:5] == `ASD_OP3_REG_READ);
	assign is_register_write_cmd = (op[7:5] == `ASD_OP3_REG_WRITE);
	assign is_cal = (op == `ASD_OP_SYS_OFS_CAL) | (op == `ASD_OP_SYS_GAIN_CAL) | (op == `ASD_OP_SELF_OFS_CAL);
	assign pd = (md_q == asd_pkg::ASD_MD_PD);
	assign cmd_done = bdone & (sp_q == asd_pkg::ASD_SP_CMD);
	assign go = cmd_done & (~pd | is_register_read_cmd | is_rdata | is_wake);
	assign sleep_hit = fall & (bit_cnt_q == `ASD_BIT_SEVENTH) & (sp_q == asd_pkg::ASD_SP_CMD)
		& ({sh_q[5:0], s_din} == `ASD_OP7_SLEEP) & ~pd & (md_q != asd_pkg::ASD_MD_SLEEPW);
	assign tmo_fire = cfg_timeout_en & act & (tmo_cnt_q == 16'(TIMEOUT_CYC - 1));

	// Bit capture; the interface restarts at a byte boundary after any abort.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sclk_prev_q <= 1'b0;
			bit_cnt_q <= '0;
			sh_q <= '0;
		end else if (clk_en) begin
			sclk_prev_q <= s_sclk;
			if (abort) begin
				bit_cnt_q <= '0;
				sh_q <= '0;
			end else if (fall) begin
				bit_cnt_q <= bit_cnt_q + 3'h1;
				sh_q <= op[6:0];
			end
		end
	end

	// Transfer phases of the multibyte commands.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sp_q <= asd_pkg::ASD_SP_CMD;
			wr_q <= 1'b0;
			start_q <= '0;
			left_q <= '0;
			oor_q <= 1'b0;
			adv_q <= 1'b0;
			load_q <= 1'b0;
			reg_addr_q <= '0;
			reg_wdata_q <= '0;
			reg_we_q <= 1'b0;
		end else if (clk_en) begin
			reg_we_q <= 1'b0;
			adv_q <= 1'b0;
			load_q <= 1'b0;
			if (abort) begin
				sp_q <= asd_pkg::ASD_SP_CMD;
			end else if (adv_q) begin
				if (reg_addr_q == `ASD_LAST_REG) begin
					oor_q <= 1'b1;
				end else begin
					reg_addr_q <= reg_addr_q + 5'h01;
				end
				load_q <= (sp_q == asd_pkg::ASD_SP_RDOUT);
			end else if (bdone) begin
				unique case (sp_q)
					asd_pkg::ASD_SP_CMD: begin
						if (go && (is_register_read_cmd || is_register_write_cmd)) begin
							sp_q <= asd_pkg::ASD_SP_CNT;
							wr_q <= is_register_write_cmd;
							start_q <= op[4:0];
						end else if (go && is_rdata) begin
							sp_q <= asd_pkg::ASD_SP_DATA;
							left_q <= `ASD_DATA_EXTRA;
						end
					end
					asd_pkg::ASD_SP_CNT: begin
						left_q <= op[4:0];
						reg_addr_q <= start_q;
						oor_q <= 1'b0;
						sp_q <= wr_q ? asd_pkg::ASD_SP_WDATA : asd_pkg::ASD_SP_RDOUT;
						load_q <= ~wr_q;
					end
					asd_pkg::ASD_SP_WDATA: begin
						reg_we_q <= ~oor_q;
						reg_wdata_q <= op;
						adv_q <= (left_q != 5'h00);
					end
					default: begin
						// Both read phases count the bytes that went out; only the register read-out also advances the address.
						adv_q <= (left_q != 5'h00) && (sp_q == asd_pkg::ASD_SP_RDOUT);
					end
				endcase
				if (sp_q != asd_pkg::ASD_SP_CMD && sp_q != asd_pkg::ASD_SP_CNT) begin
					if (left_q == 5'h00) begin
						sp_q <= asd_pkg::ASD_SP_CMD;
					end else begin
						left_q <= left_q - 5'h01;
					end
				end
			end
		end
	end

	// Output shifter: loads between bytes, shifts on rising sclk edges.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_q <= '0;
			dout_q <= 1'b0;
			dout_oe_q <= 1'b0;
		end else if (clk_en) begin
			dout_oe_q <= act;
			if (abort) begin
				tx_q <= '0;
				dout_q <= 1'b0;
			end else if (go && is_rdata) begin
				tx_q <= hold_q;
			end else if (load_q) begin
				// zero byte when out of range
				tx_q <= {(oor_q ? 8'h00 : reg_rdata), 16'h0000};
			end else if (rise) begin
				dout_q <= tx_q[23];
				tx_q <= {tx_q[22:0], 1'b0};
			end
		end
	end

	// The holding buffer always takes new results, so nothing is lost.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hold_q <= '0;
			shift_load_block_q <= 1'b0;
		end else if (clk_en) begin
			if (conv_done) begin
				hold_q <= result_data;
			end
			shift_load_block_q <= (sp_q == asd_pkg::ASD_SP_CNT) | (sp_q == asd_pkg::ASD_SP_RDOUT)
				| (sp_q == asd_pkg::ASD_SP_WDATA);
		end
	end

	// Operating mode. Undefined opcodes fall through every branch untouched.
	// undefined opcodes ignored
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			md_q <= asd_pkg::ASD_MD_STANDBY;
			slp_cnt_q <= '0;
			conv_start_q <= 1'b0;
			conv_abort_q <= 1'b0;
			filter_clr_q <= 1'b0;
			cfg_default_q <= 1'b0;
			int_osc_sel_q <= 1'b0;
		end else if (clk_en) begin
			conv_start_q <= 1'b0;
			conv_abort_q <= 1'b0;
			filter_clr_q <= 1'b0;
			cfg_default_q <= 1'b0;
			int_osc_sel_q <= 1'b0;
			if (!s_rstp) begin
				// The reset pin behaves like the reset command.
				md_q <= asd_pkg::ASD_MD_STANDBY;
				filter_clr_q <= 1'b1;
				cfg_default_q <= 1'b1;
				int_osc_sel_q <= 1'b1;
			end else if (sleep_hit) begin
				md_q <= asd_pkg::ASD_MD_SLEEPW;
				slp_cnt_q <= `ASD_SLEEP_CYC;
				conv_abort_q <= converting_q;
			end else if (go && !is_idle) begin
				if (is_wake && pd) begin
					md_q <= asd_pkg::ASD_MD_STANDBY;
				end else if (is_reset) begin
					md_q <= asd_pkg::ASD_MD_STANDBY;
					filter_clr_q <= 1'b1;
					cfg_default_q <= 1'b1;
					int_osc_sel_q <= 1'b1;
				end else if (is_start && !s_start && md_q == asd_pkg::ASD_MD_STANDBY) begin
					md_q <= asd_pkg::ASD_MD_CONVERT;
					conv_start_q <= 1'b1;
				end else if (is_stop && !cfg_single_shot && md_q == asd_pkg::ASD_MD_CONVERT) begin
					md_q <= asd_pkg::ASD_MD_STOPPING;
				end
			end else begin
				unique case (md_q)
					asd_pkg::ASD_MD_SLEEPW: begin
						if (slp_cnt_q == 2'h1) begin
							md_q <= asd_pkg::ASD_MD_PD;
						end else begin
							slp_cnt_q <= slp_cnt_q - 2'h1;
						end
					end
					asd_pkg::ASD_MD_CONVERT: begin
						if (conv_done && cfg_single_shot) begin
							md_q <= asd_pkg::ASD_MD_STANDBY;
						end
					end
					asd_pkg::ASD_MD_STOPPING: begin
						if (conv_done) begin
							md_q <= asd_pkg::ASD_MD_STANDBY;
						end
					end
					asd_pkg::ASD_MD_STANDBY, asd_pkg::ASD_MD_PD: begin
						md_q <= md_q;
					end
					default: begin
						md_q <= asd_pkg::ASD_MD_STANDBY;
					end
				endcase
			end
		end
	end

	// Mode flags are registered once more so the outputs come from flip-flops.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			converting_q <= 1'b0;
			powered_down_q <= 1'b0;
		end else if (clk_en) begin
			converting_q <= (md_q == asd_pkg::ASD_MD_CONVERT) | (md_q == asd_pkg::ASD_MD_STOPPING);
			powered_down_q <= pd;
		end
	end

	// Calibration; the host is trusted to supply the input condition.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cal_busy_q <= 1'b0;
			cal_start_q <= 1'b0;
			cal_kind_q <= asd_pkg::ASD_CAL_SYS_OFS;
			inputs_short_q <= 1'b0;
			offset_correction_upd_q <= 1'b0;
			fullscale_correction_upd_q <= 1'b0;
		end else if (clk_en) begin
			cal_start_q <= 1'b0;
			offset_correction_upd_q <= 1'b0;
			fullscale_correction_upd_q <= 1'b0;
			if (go && is_cal && md_q == asd_pkg::ASD_MD_CONVERT && !cal_busy_q) begin
				cal_busy_q <= 1'b1;
				cal_start_q <= 1'b1;
				cal_kind_q <= (op == `ASD_OP_SYS_OFS_CAL) ? asd_pkg::ASD_CAL_SYS_OFS :
					(op == `ASD_OP_SYS_GAIN_CAL) ? asd_pkg::ASD_CAL_SYS_GAIN : asd_pkg::ASD_CAL_SELF_OFS;
				inputs_short_q <= (op == `ASD_OP_SELF_OFS_CAL);
			end else if (cal_done && cal_busy_q) begin
				cal_busy_q <= 1'b0;
				inputs_short_q <= 1'b0;
				offset_correction_upd_q <= (cal_kind_q != asd_pkg::ASD_CAL_SYS_GAIN);
				fullscale_correction_upd_q <= (cal_kind_q == asd_pkg::ASD_CAL_SYS_GAIN);
			end
		end
	end

	// Timeout counter; restarted by every complete byte.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tmo_cnt_q <= '0;
		end else if (clk_en) begin
			if (!cfg_timeout_en || !act || bdone || tmo_fire) begin
				tmo_cnt_q <= '0;
			end else begin
				tmo_cnt_q <= tmo_cnt_q + 16'h0001;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst || !clk_en);

	property p_idle;
		go && is_idle && s_rstp && !conv_done |=> $stable(md_q) && !conv_start_q && !filter_clr_q;
	endproperty
	a_idle: assert property (p_idle) else $error("idle opcode changed state");
	property p_wake;
		go && is_wake && pd |=> md_q == asd_pkg::ASD_MD_STANDBY ##1 !powered_down_q;
	endproperty
	a_wake: assert property (p_wake) else $error("exit sleep did not reach standby");
	property p_sleep;
		sleep_hit && s_rstp |-> ##3 pd ##1 powered_down_q;
	endproperty
	a_sleep: assert property (p_sleep) else $error("power-down not entered on time");
	property p_pd_filter;
		cmd_done && pd && s_rstp && (is_start || is_reset) |=> !conv_start_q && !filter_clr_q;
	endproperty
	a_pd_filter: assert property (p_pd_filter) else $error("command acted in power-down");
	property p_reset;
		go && is_reset && s_rstp |=> filter_clr_q && cfg_default_q && md_q == asd_pkg::ASD_MD_STANDBY;
	endproperty
	a_reset: assert property (p_reset) else $error("reset command incomplete");
	property p_osc;
		cfg_default_q |-> int_osc_sel_q;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator not reselected");
	property p_start_pin;
		go && is_start && s_start |=> !conv_start_q;
	endproperty
	a_start_pin: assert property (p_start_pin) else $error("start taken with pin high");
	property p_stop;
		md_q == asd_pkg::ASD_MD_STOPPING && conv_done && !go && s_rstp && !sleep_hit |=> ##1 !converting_q;
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not end conversions");
	property p_cal;
		cal_busy_q && cal_done && !(go && is_cal) |=>
			(offset_correction_upd_q != fullscale_correction_upd_q) && !inputs_short_q;
	endproperty
	a_cal: assert property (p_cal) else $error("calibration finish missed");
	property p_zero;
		load_q && oor_q && !abort |=> tx_q[23:16] == 8'h00;
	endproperty
	a_zero: assert property (p_zero) else $error("out of range read not zero");
	property p_block;
		bdone && !abort && sp_q != asd_pkg::ASD_SP_CMD |=> !conv_start_q && !cal_start_q;
	endproperty
	a_block: assert property (p_block) else $error("command decoded mid transfer");
	property p_discard;
		reg_we_q |-> !oor_q;
	endproperty
	a_discard: assert property (p_discard) else $error("write past the map");
	property p_float;
		s_cs_n |=> !dout_oe_q && sp_q == asd_pkg::ASD_SP_CMD;
	endproperty
	a_float: assert property (p_float) else $error("output driven without chip select");
	c_register_read_cmd: cover property (sp_q == asd_pkg::ASD_SP_RDOUT && bdone && left_q == 5'h00);
	c_register_write_cmd: cover property (reg_we_q ##[1:200] reg_we_q);
	c_pd: cover property (powered_down_q ##[1:1000] !powered_down_q);
	c_conv: cover property (conv_start_q ##[1:1000] md_q == asd_pkg::ASD_MD_STOPPING);
endmodule : asd_decoder

//--- asd_host.sv
// Host model: an SPI mode 1 bus master that drives the decoder's serial pins.
`timescale 1ns/100ps
module asd_host (
	input wire logic clk,
	output logic cs_n_pin,
	output logic sclk_pin,
	output logic din_pin,
	input wire logic dout_q
);
	// Half of the 160 ns serial clock, counted in master clocks.
	localparam int HALF = 8;
	// The bus starts released, with the serial clock parked low.
	initial begin
		cs_n_pin = 1'b1;
		sclk_pin = 1'b0;
		din_pin = 1'b0;
	end
	// release between commands
	// The data line toggles while released, so a stale bit never looks valid.
	task automatic idle(input int n);
		repeat (n) begin
			@(negedge clk);
			cs_n_pin = 1'b1;
			din_pin = ~din_pin;
		end
	endtask : idle
	// MSB first, change on rise
	// Chip select drops a half period ahead of the first edge and then stays low.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		@(negedge clk);
		if (cs_n_pin) begin
			cs_n_pin = 1'b0;
			repeat (HALF) @(negedge clk);
		end
		for (int i = 7; i >= 0; i--) begin
			sclk_pin = 1'b1;
			din_pin = tx[i];
			repeat (HALF) @(negedge clk);
			sclk_pin = 1'b0;
			rx[i] = dout_q;
			repeat (HALF) @(negedge clk);
		end
	endtask : xfer
endmodule : asd_host

//--- asd_decoder_test.sv
// Self-checking bench of the serial command decoder.
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module asd_decoder_test;
	// Every stimulus gets its first value in the initial block, so none is tied off.
	logic clk, sys_rst, clk_en, rst_pin_n, start_pin, single, tmo_en, conv_done, cal_done;
	logic [23:0] result;
	logic cs_n_pin, sclk_pin, din_pin, dout_q, dout_oe_q, reg_we_q, converting_q, powered_down_q;
	logic conv_start_q, conv_abort_q, filter_clr_q, cfg_default_q, int_osc_sel_q, cal_start_q;
	logic inputs_short_q, ofs_upd, fs_upd, shift_load_block_q;
	logic [4:0] reg_addr_q;
	logic [7:0] reg_wdata_q, rx;
	logic [23:0] v;
	asd_pkg::asd_cal_e cal_kind_q;
	logic [7:0] mem [0:31];
	int bad_count = 0;
	int comparisons = 0;
	int n_start = 0, n_abort = 0, n_clr = 0, n_osc = 0, n_cal = 0, n_ofs = 0, n_fs = 0, n_we = 0;
	// The timeout is shortened so that it fires within a few hundred cycles.
	asd_decoder #(.TIMEOUT_CYC(200)) i_asd_decoder (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .din_pin(din_pin), .start_pin(start_pin), .rst_pin_n(rst_pin_n),
		.cfg_single_shot(single), .cfg_timeout_en(tmo_en), .conv_done(conv_done), .result_data(result),
		.cal_done(cal_done), .reg_rdata({3'h5, reg_addr_q}), .dout_q(dout_q), .dout_oe_q(dout_oe_q),
		.reg_addr_q(reg_addr_q), .reg_wdata_q(reg_wdata_q), .reg_we_q(reg_we_q), .converting_q(converting_q),
		.powered_down_q(powered_down_q), .conv_start_q(conv_start_q), .conv_abort_q(conv_abort_q),
		.filter_clr_q(filter_clr_q), .cfg_default_q(cfg_default_q), .int_osc_sel_q(int_osc_sel_q),
		.cal_start_q(cal_start_q), .cal_kind_q(cal_kind_q), .inputs_short_q(inputs_short_q),
		.offset_correction_upd_q(ofs_upd), .fullscale_correction_upd_q(fs_upd),
		.shift_load_block_q(shift_load_block_q));
	asd_host i_asd_host (.clk(clk), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .din_pin(din_pin), .dout_q(dout_q));
	// master clock never stops
	// The master clock runs through sleep and exit-sleep, as the host must keep it.
	always #5 clk = ~clk;
	// Pulse counters and a copy of every register write, for later comparison.
	always @(posedge clk) begin
		n_start += (conv_start_q === 1'b1);
		n_abort += (conv_abort_q === 1'b1);
		n_clr += (filter_clr_q === 1'b1 && cfg_default_q === 1'b1);
		n_osc += (int_osc_sel_q === 1'b1);
		n_cal += (cal_start_q === 1'b1);
		n_ofs += (ofs_upd === 1'b1);
		n_fs += (fs_upd === 1'b1);
		n_we += (reg_we_q === 1'b1);
		if (reg_we_q === 1'b1) mem[reg_addr_q] = reg_wdata_q;
	end
	task automatic send(input logic [7:0] b);
		i_asd_host.xfer(b, rx);
		i_asd_host.idle(20);
	endtask : send
	task automatic conv(input logic [23:0] d);
		result = d;
		conv_done = 1'b1;
		@(negedge clk);
		conv_done = 1'b0;
		repeat (4) @(negedge clk);
	endtask : conv
	task automatic rd24(output logic [23:0] d);
		i_asd_host.xfer(8'h12, rx);
		repeat (3) begin
			i_asd_host.xfer(8'h00, rx);
			d = {d[15:0], rx};
		end
		i_asd_host.idle(20);
	endtask : rd24
	task automatic t_start_stop;
		start_pin = 1'b1;
		send(8'h08);
		`CHK(converting_q, 1'b0)
		start_pin = 1'b0;
		send(8'h09);
		`CHK(converting_q, 1'b1)
		send(8'h08);
		`CHK(n_start, 1)
		send(8'h00);
		send(8'h1f);
		`CHK(converting_q, 1'b1)
		`CHK(n_abort + n_clr, 0)
		send(8'h0b);
		`CHK(converting_q, 1'b1)
		conv(24'h111111);
		`CHK(converting_q, 1'b0)
		single = 1'b1;
		send(8'h08);
		send(8'h0a);
		`CHK(converting_q, 1'b1)
		conv(24'h222222);
		`CHK(converting_q, 1'b0)
		single = 1'b0;
	endtask : t_start_stop
	task automatic t_cal;
		logic [7:0] ops [3] = '{8'h16, 8'h17, 8'h19};
		send(8'h08);
		for (int k = 0; k < 3; k++) begin
			send(ops[k]);
			`CHK(cal_kind_q, asd_pkg::asd_cal_e'(k))
			`CHK(inputs_short_q, k == 2)
			cal_done = 1'b1;
			@(negedge clk);
			cal_done = 1'b0;
			repeat (4) @(negedge clk);
		end
		`CHK({n_cal, n_ofs, n_fs}, {32'd3, 32'd2, 32'd1})
	endtask : t_cal
	task automatic t_read_data;
		conv(24'hc3a51e);
		i_asd_host.xfer(8'h12, rx);
		fork
			repeat (3) begin
				i_asd_host.xfer(8'h00, rx);
				v = {v[15:0], rx};
			end
			begin
				repeat (30) @(negedge clk);
				conv(24'h0f0f0f);
			end
		join
		i_asd_host.idle(20);
		`CHK(v, 24'hc3a51e)
	endtask : t_read_data
	task automatic t_regs;
		int c = n_clr;
		int w = n_we;
		i_asd_host.xfer(8'h30, rx);
		i_asd_host.xfer(8'h02, rx);
		i_asd_host.xfer(8'h06, rx);
		`CHK(rx, 8'hb0)
		conv(24'h5a6b7c);
		`CHK(shift_load_block_q, 1'b1)
		i_asd_host.xfer(8'h06, rx);
		`CHK(rx, 8'hb1)
		`CHK(dout_oe_q, 1'b1)
		i_asd_host.xfer(8'h06, rx);
		`CHK(rx, 8'h00)
		i_asd_host.idle(20);
		`CHK(n_clr, c)
		rd24(v);
		`CHK(v, 24'h5a6b7c)
		for (int i = 0; i < 4; i++) i_asd_host.xfer(i[1] ? (i[0] ? 8'hee : 8'h11) : (i[0] ? 8'h02 : 8'h50), rx);
		i_asd_host.xfer(8'h04, rx);
		i_asd_host.idle(20);
		`CHK({mem[5'h10], mem[5'h11]}, 16'h11ee)
		`CHK(n_we, w + 2)
		`CHK(powered_down_q, 1'b0)
	endtask : t_regs
	task automatic t_timeout_reset;
		int c = n_clr;
		int o = n_osc;
		send(8'h08);
		tmo_en = 1'b1;
		i_asd_host.xfer(8'h45, rx);
		repeat (250) @(negedge clk);
		send(8'h06);
		tmo_en = 1'b0;
		`CHK(n_clr, c + 1)
		`CHK(converting_q, 1'b0)
		`CHK(n_osc, o + 1)
		i_asd_host.idle(50);
	endtask : t_timeout_reset
	task automatic t_sleep;
		int a;
		int s;
		i_asd_host.xfer(8'h45, rx);
		i_asd_host.idle(20);
		`CHK(dout_oe_q, 1'b0)
		send(8'h08);
		a = n_abort;
		send(8'h04);
		`CHK(powered_down_q, 1'b1)
		`CHK(n_abort, a + 1)
		s = n_start;
		send(8'h08);
		`CHK(n_start, s)
		rd24(v);
		`CHK(v, 24'h5a6b7c)
		send(8'h02);
		`CHK({powered_down_q, converting_q}, 2'h0)
	endtask : t_sleep
	// A frozen clock enable swallows a start; the reset pin then ends a register read.
	task automatic t_pins;
		int c;
		clk_en = 1'b0;
		send(8'h08);
		clk_en = 1'b1;
		`CHK(converting_q, 1'b0)
		send(8'h09);
		i_asd_host.xfer(8'h20, rx);
		i_asd_host.xfer(8'h07, rx);
		c = n_clr;
		rst_pin_n = 1'b0;
		repeat (10) @(negedge clk);
		rst_pin_n = 1'b1;
		repeat (10) @(negedge clk);
		`CHK({n_clr, converting_q}, {c + 10, 1'b0})
		send(8'h09);
		`CHK(converting_q, 1'b1)
	endtask : t_pins
	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	// Watchdog: a hang counts as a mismatch and closes the run.
	initial begin
		repeat (100000) @(posedge clk);
		bad_count++;
		test_done();
	end
	initial begin
		// Reset asserted, clock enable high, reset pin inactive, all other inputs low.
		{clk, sys_rst, clk_en, rst_pin_n} = 4'h7;
		{start_pin, single, tmo_en, conv_done, cal_done, result} = 29'h0000000;
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		repeat (6) @(negedge clk);
		`CHK({dout_oe_q, converting_q, powered_down_q}, 3'h0)
		t_start_stop();
		t_cal();
		t_read_data();
		t_regs();
		t_timeout_reset();
		t_sleep();
		t_pins();
		test_done();
	end
endmodule : asd_decoder_test
